// File: hw/hco_defines.svh
// Purpose: Offsets, field positions, reset values and sizes of the
//          hardware cursor overlay.
// Assumes: Indexed display-controller data port, 8-bit registers.
// Notes:   One line per rule below, tag first.
// Function
// - Cursor is 64x64, mask and inversion planes
// - Mask/inversion pair picks colour, pixel or inverse
// - Mask at base, inversion plane base plus 512
// - Two 64-bit line registers reloaded before cursor lines
// - Post-lookup inversion complements full-colour lookup output
// - Height bit 7 moves inversion before lookup
// - Active region X..X+63, Y..Y+height-1
// - Height bits 6-0; zero disables cursor
// - Height register resets to 00h, cursor off
// - Width fixed at 64; padding shows frame buffer
// - Two colours as six 8-bit RW registers
// - Base low holds bits 15-9; bit 0 reserved
// - Base mid holds address bits 23-16
// - Base high holds bits 26-24; upper reserved
// - Planes read MSB first, left-right, top-bottom
// - Registers at indices 29h-32h of data port
`ifndef HCO_DEFINES_SVH
`define HCO_DEFINES_SVH

// Register indices on the data port
`define HCO_IDX_HEIGHT   8'h29
`define HCO_IDX_C0_RED   8'h2A
`define HCO_IDX_C0_GREEN 8'h2B
`define HCO_IDX_C0_BLUE  8'h2C
`define HCO_IDX_C1_RED   8'h2D
`define HCO_IDX_C1_GREEN 8'h2E
`define HCO_IDX_C1_BLUE  8'h2F
`define HCO_IDX_BASE_LOW 8'h30
`define HCO_IDX_BASE_MID 8'h31
`define HCO_IDX_BASE_HI  8'h32

// Field positions
`define HCO_PRE_LUT_BIT  7
`define HCO_HEIGHT_MSB   6
`define HCO_BASE_LOW_LSB 1
`define HCO_BASE_HI_MSB  2

// Reset values and unmapped read value
`define HCO_HEIGHT_RST   8'h00
`define HCO_READ_NONE    8'h00

// Geometry
`define HCO_WIDTH        12'h040
`define HCO_XOR_OFFSET   27'h0000200
`define HCO_LINE_SHIFT   3

`endif

// File: hw/hco_pkg.sv
// Purpose: Types of the hardware cursor overlay.
// Assumes: Constants come from hco_defines.svh.
// Notes:   All state of each module is one packed struct.
package hco_pkg;

    // Fetch sequencer, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MASK = 3'b010,
        ST_INV  = 3'b100
    } hco_fetch_t;

    // Core state
    typedef struct packed {
        logic [7:0]      heightCtl;
        logic [5:0][7:0] colour;
        logic [6:0]      baseLow;
        logic [7:0]      baseMid;
        logic [2:0]      baseHigh;
        logic [7:0]      rdData;
        hco_fetch_t      fetch;
        logic            lineHit;
        logic            memReq;
        logic [26:0]     memAddr;
        logic            s1Valid;
        logic            s1Inside;
        logic [15:0]     s1Idx;
        logic [23:0]     s1Rgb;
        logic            s1Indexed;
        logic [15:0]     lutAddr;
        logic            s2Valid;
        logic            s2Inside;
        logic [1:0]      s2Bits;
        logic [23:0]     s2Rgb;
        logic            s2Indexed;
        logic            s2Pre;
        logic            outValid;
        logic [23:0]     outRgb;
    } hco_core_t;

    // Line store state
    typedef struct packed {
        logic [63:0] maskLine;
        logic [63:0] invLine;
        logic        maskBit;
        logic        invBit;
    } hco_line_t;

endpackage

// File: hw/hco_line_store.sv
// Purpose: Holds one scan line of the mask and inversion planes.
// Assumes: Memory word byte 0 is the lowest address.
// Notes:   Bit 63 of a stored line is the leftmost cursor pixel.
`timescale 1ns/10ps
`include "hco_defines.svh"

module hco_line_store (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wrMask,
    input  wire logic        wrInv,
    input  wire logic [63:0] wrData,
    input  wire logic [5:0]  rdCol,
    output logic             maskBit,
    output logic             invBit
);

    hco_pkg::hco_line_t cur;
    hco_pkg::hco_line_t nxt_cur;
    logic [63:0]        ordered;

    // Byte k bit 7 is pixel 8k, bit 0 pixel 8k+7
    genvar p;
    generate
        for (p = 0; p < 64; p = p + 1) begin : g_ord
            assign ordered[63-p] = wrData[8*(p/8) + 7 - (p%8)];
        end
    endgenerate

    // Load a line, read one column per cycle
    always_comb begin
        nxt_cur = cur;
        if (wrMask) begin
            nxt_cur.maskLine = ordered;
        end
        if (wrInv) begin
            nxt_cur.invLine = ordered;
        end
        nxt_cur.maskBit = cur.maskLine[6'h3F - rdCol];
        nxt_cur.invBit  = cur.invLine[6'h3F - rdCol];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= nxt_cur;
        end
    end

    assign maskBit = cur.maskBit;
    assign invBit  = cur.invBit;

endmodule

// File: hw/hco_overlay.sv
// Purpose: Hardware cursor overlay on the display pixel stream.
// Assumes: One pixel clock; lookup table reads lutAddr combinationally.
// Notes:   Pixel result appears three clocks after pixValid.
`timescale 1ns/10ps
`include "hco_defines.svh"

module hco_overlay (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  regIndex,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [7:0]  regRdData,
    input  wire logic [11:0] posX,
    input  wire logic [11:0] posY,
    input  wire logic        lineStart,
    input  wire logic [11:0] lineNum,
    output logic             memReq,
    output logic      [26:0] memAddr,
    input  wire logic        memAck,
    input  wire logic [63:0] memData,
    input  wire logic        pixValid,
    input  wire logic [11:0] pixX,
    input  wire logic [15:0] pixIdx,
    input  wire logic [23:0] pixRgb,
    input  wire logic        pixIndexed,
    output logic      [15:0] lutAddr,
    input  wire logic [23:0] lutData,
    output logic             outValid,
    output logic      [23:0] outRgb
);

    hco_pkg::hco_core_t cur;
    hco_pkg::hco_core_t nxt_cur;

    logic        maskBit;
    logic        invBit;
    logic        wrMask;
    logic        wrInv;
    logic [6:0]  height;
    logic        preLut;
    logic [26:0] baseAddr;
    logic [26:0] rowOffset;
    logic [11:0] lineDiff;
    logic        hitV;
    logic [11:0] colX;
    logic        inX;
    logic [23:0] colourZero;
    logic [23:0] colourOne;
    logic [23:0] basePix;

    // Register fields in use
    assign height = cur.heightCtl[`HCO_HEIGHT_MSB:0];
    assign preLut = cur.heightCtl[`HCO_PRE_LUT_BIT];
    assign colourZero = {cur.colour[0], cur.colour[1],
                         cur.colour[2]};
    assign colourOne  = {cur.colour[3], cur.colour[4],
                         cur.colour[5]};

    // Mask plane base from the three base registers
    assign baseAddr = {cur.baseHigh, cur.baseMid, cur.baseLow,
                       9'h000};

    // Vertical hit for the coming line
    assign lineDiff = lineNum - posY;
    assign hitV     = (height != 7'h00)
                    && (lineNum >= posY)
                    && (lineDiff < {5'h00, height});

    // Each plane row is eight bytes
    assign rowOffset = {18'h00000, lineDiff[5:0],
                        3'h0};

    // Horizontal window, always 64 wide
    assign colX = pixX - posX;
    assign inX  = (pixX >= posX)
                && (colX < `HCO_WIDTH);

    // Line loads happen on the memory answer
    assign wrMask = memAck && (cur.fetch == hco_pkg::ST_MASK);
    assign wrInv  = memAck && (cur.fetch == hco_pkg::ST_INV);

    // Mask and inversion line registers
    hco_line_store u_lines (
        .clk     (clk),
        .rst     (rst),
        .wrMask  (wrMask),
        .wrInv   (wrInv),
        .wrData  (memData),
        .rdCol   (colX[5:0]),
        .maskBit (maskBit),
        .invBit  (invBit)
    );

    // Pixel chosen from the lookup or straight from the stream
    assign basePix = cur.s2Indexed ? lutData : cur.s2Rgb;

    // Next state of registers, fetch and pixel pipeline
    always_comb begin
        nxt_cur = cur;

        // Register writes through the indexed data port
        if (regWrEn) begin
            unique case (regIndex)
                `HCO_IDX_HEIGHT: begin
                    nxt_cur.heightCtl = regWrData;
                end
                `HCO_IDX_C0_RED: begin
                    nxt_cur.colour[0] = regWrData;
                end
                `HCO_IDX_C0_GREEN: begin
                    nxt_cur.colour[1] = regWrData;
                end
                `HCO_IDX_C0_BLUE: begin
                    nxt_cur.colour[2] = regWrData;
                end
                `HCO_IDX_C1_RED: begin
                    nxt_cur.colour[3] = regWrData;
                end
                `HCO_IDX_C1_GREEN: begin
                    nxt_cur.colour[4] = regWrData;
                end
                `HCO_IDX_C1_BLUE: begin
                    nxt_cur.colour[5] = regWrData;
                end
                `HCO_IDX_BASE_LOW: begin
                    // Reserved bit 0 is not stored
                    nxt_cur.baseLow =
                        regWrData[7:`HCO_BASE_LOW_LSB];
                end
                `HCO_IDX_BASE_MID: begin
                    nxt_cur.baseMid = regWrData;
                end
                `HCO_IDX_BASE_HI: begin
                    // Reserved bits 7-3 are not stored
                    nxt_cur.baseHigh =
                        regWrData[`HCO_BASE_HI_MSB:0];
                end
                default: begin
                    // Other indices belong to other blocks
                end
            endcase
        end

        // Register reads; value holds until the next read
        if (regRdEn) begin
            unique case (regIndex)
                `HCO_IDX_HEIGHT: begin
                    nxt_cur.rdData = cur.heightCtl;
                end
                `HCO_IDX_C0_RED: begin
                    nxt_cur.rdData = cur.colour[0];
                end
                `HCO_IDX_C0_GREEN: begin
                    nxt_cur.rdData = cur.colour[1];
                end
                `HCO_IDX_C0_BLUE: begin
                    nxt_cur.rdData = cur.colour[2];
                end
                `HCO_IDX_C1_RED: begin
                    nxt_cur.rdData = cur.colour[3];
                end
                `HCO_IDX_C1_GREEN: begin
                    nxt_cur.rdData = cur.colour[4];
                end
                `HCO_IDX_C1_BLUE: begin
                    nxt_cur.rdData = cur.colour[5];
                end
                `HCO_IDX_BASE_LOW: begin
                    nxt_cur.rdData = {cur.baseLow, 1'b0};
                end
                `HCO_IDX_BASE_MID: begin
                    nxt_cur.rdData = cur.baseMid;
                end
                `HCO_IDX_BASE_HI: begin
                    nxt_cur.rdData = {5'h00, cur.baseHigh};
                end
                default: begin
                    nxt_cur.rdData = `HCO_READ_NONE;
                end
            endcase
        end

        // Line fetch: mask word, then inversion word
        unique case (cur.fetch)
            hco_pkg::ST_IDLE: begin
                nxt_cur.memReq = 1'b0;
            end
            hco_pkg::ST_MASK: begin
                if (memAck) begin
                    nxt_cur.fetch   = hco_pkg::ST_INV;
                    nxt_cur.memAddr = cur.memAddr
                                    + `HCO_XOR_OFFSET;
                end
            end
            hco_pkg::ST_INV: begin
                if (memAck) begin
                    nxt_cur.fetch   = hco_pkg::ST_IDLE;
                    nxt_cur.memReq  = 1'b0;
                    nxt_cur.lineHit = 1'b1;
                end
            end
            default: begin
                nxt_cur.fetch  = hco_pkg::ST_IDLE;
                nxt_cur.memReq = 1'b0;
            end
        endcase

        // A new line drops the old one and reloads if the cursor is on it
        if (lineStart) begin
            nxt_cur.lineHit = 1'b0;
            if (hitV) begin
                nxt_cur.fetch   = hco_pkg::ST_MASK;
                nxt_cur.memReq  = 1'b1;
                nxt_cur.memAddr = baseAddr + rowOffset;
            end else begin
                // No line outside the cursor rows or with height zero: cursor hidden
                nxt_cur.fetch  = hco_pkg::ST_IDLE;
                nxt_cur.memReq = 1'b0;
            end
        end

        // Stage 1: capture pixel, line store reads its column
        nxt_cur.s1Valid   = pixValid;
        nxt_cur.s1Inside  = pixValid && inX && cur.lineHit;
        nxt_cur.s1Idx     = pixIdx;
        nxt_cur.s1Rgb     = pixRgb;
        nxt_cur.s1Indexed = pixIndexed;

        // Stage 2: lookup address, inverted first in pre-lookup mode
        if (cur.s1Inside && maskBit && invBit && preLut
            && cur.s1Indexed) begin
            nxt_cur.lutAddr = ~cur.s1Idx;
        end else begin
            nxt_cur.lutAddr = cur.s1Idx;
        end
        nxt_cur.s2Valid   = cur.s1Valid;
        nxt_cur.s2Inside  = cur.s1Inside;
        nxt_cur.s2Bits    = {maskBit, invBit};
        nxt_cur.s2Rgb     = cur.s1Rgb;
        nxt_cur.s2Indexed = cur.s1Indexed;
        nxt_cur.s2Pre     = preLut;

        // Stage 3: combine cursor with the pixel
        nxt_cur.outValid = cur.s2Valid;
        if (!cur.s2Inside) begin
            nxt_cur.outRgb = basePix;
        end else begin
            unique case (cur.s2Bits)
                2'b00: begin
                    nxt_cur.outRgb = colourZero;
                end
                2'b01: begin
                    nxt_cur.outRgb = colourOne;
                end
                2'b10: begin
                    nxt_cur.outRgb = basePix;
                end
                2'b11: begin
                    // Index already inverted in pre-lookup mode
                    if (cur.s2Pre && cur.s2Indexed) begin
                        nxt_cur.outRgb = basePix;
                    end else begin
                        nxt_cur.outRgb = ~basePix;
                    end
                end
            endcase
        end
    end

    // State register; colours and base also cleared for determinism
    always_ff @(posedge clk) begin
        if (rst) begin
            cur           <= '0;
            cur.heightCtl <= `HCO_HEIGHT_RST;
            cur.fetch     <= hco_pkg::ST_IDLE;
        end else begin
            cur <= nxt_cur;
        end
    end

    // Outputs straight from the state register
    assign regRdData = cur.rdData;
    assign memReq    = cur.memReq;
    assign memAddr   = cur.memAddr;
    assign lutAddr   = cur.lutAddr;
    assign outValid  = cur.outValid;
    assign outRgb    = cur.outRgb;

endmodule

// File: tb/hco_overlay_properties.sv
// Purpose: Port checks of the cursor overlay.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Height field is shadowed from register writes.
`timescale 1ns/10ps
module hco_overlay_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  regIndex,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [7:0]  regRdData,
    input wire logic [11:0] posY,
    input wire logic        lineStart,
    input wire logic [11:0] lineNum,
    input wire logic        memReq,
    input wire logic [26:0] memAddr,
    input wire logic        memAck,
    input wire logic        pixValid,
    input wire logic        outValid
);
    logic [6:0]  hgt_ff;
    logic [11:0] rowGap;
    logic        hitLine;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Shadow height, takes effect like the register itself
    always_ff @(posedge clk) begin
        if (rst) hgt_ff <= 7'h00;
        else if (regWrEn && regIndex == 8'h29) hgt_ff <= regWrData[6:0];
    end
    // Line falls inside the cursor rows
    assign rowGap  = lineNum - posY;
    assign hitLine = lineNum >= posY && rowGap < {5'h00, hgt_ff};
    property p_reset_quiet;
        disable iff (1'b0) rst |=> regRdData == 8'h00 && !memReq && !outValid;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs busy after reset");
    property p_out_pipe;
        pixValid |-> ##3 outValid;
    endproperty
    a_out_pipe: assert property (p_out_pipe)
        else $error("pixel lost in pipe");
    property p_unmapped;
        regRdEn && (regIndex < 8'h29 || regIndex > 8'h32) |=> regRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_height_rb;
        regWrEn && regIndex == 8'h29 ##1 regRdEn && regIndex == 8'h29
            |=> regRdData == $past(regWrData, 2);
    endproperty
    a_height_rb: assert property (p_height_rb)
        else $error("height readback wrong");
    property p_req_hold;
        memReq && !memAck && !lineStart |=> memReq && $stable(memAddr);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped early");
    property p_inv_addr;
        memReq && memAck && !lineStart ##1 memReq
            |-> memAddr == $past(memAddr) + 27'h0000200;
    endproperty
    a_inv_addr: assert property (p_inv_addr)
        else $error("second word address wrong");
    property p_no_fetch;
        lineStart && !hitLine |=> !memReq;
    endproperty
    a_no_fetch: assert property (p_no_fetch)
        else $error("fetch outside cursor rows");
    property p_fetch;
        lineStart && hitLine |=> memReq && memAddr[8:0] == {rowGap[5:0], 3'h0};
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("line fetch missing");
    c_fetch: cover property (memReq && memAck);
    c_pixel: cover property (outValid);
    c_read: cover property (regRdEn && regIndex == 8'h29);
endmodule

bind hco_overlay hco_overlay_checker u_chk (.clk(clk), .rst(rst),
    .regIndex(regIndex), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .posY(posY),
    .lineStart(lineStart), .lineNum(lineNum), .memReq(memReq),
    .memAddr(memAddr), .memAck(memAck), .pixValid(pixValid),
    .outValid(outValid));

// File: tb/hco_mem_model.sv
// Purpose: Frame memory and colour lookup beside the overlay.
// Assumes: Line words indexed by address bits 9:3 of a 1 KByte image.
// Notes:   Idle data lines toggle between the last word and its inverse.
`timescale 1ns/10ps
module hco_mem_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  ackWait,
    input  wire logic        memReq,
    input  wire logic [26:0] memAddr,
    output logic             memAck,
    output logic      [63:0] memData,
    input  wire logic [15:0] lutAddr,
    output logic      [23:0] lutData
);
    logic [63:0] memWord [0:127];
    logic [26:0] lastAddr_ff;
    logic [3:0]  wait_ff;
    // Answer a word after ackWait cycles, then leave one idle cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            memAck <= 1'b0;
            wait_ff <= 4'h0;
            memData <= 64'h0;
        end else if (memAck || !memReq) begin
            memAck <= 1'b0;
            wait_ff <= 4'h0;
            memData <= ~memData;
        end else if (wait_ff >= ackWait) begin
            memAck <= 1'b1;
            memData <= memWord[memAddr[9:3]];
            lastAddr_ff <= memAddr;
        end else wait_ff <= wait_ff + 4'h1;
    end
    // Lookup answers in the same cycle
    assign lutData = {lutAddr[7:0], lutAddr[15:8], lutAddr[7:0] ^ 8'h5A};
endmodule

// File: tb/hco_overlay_test.sv
// Purpose: Self-checking bench of the cursor overlay.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Base 5120400h, cursor at column 64h, row 10h.
`timescale 1ns/10ps
module hco_overlay_test;
    localparam logic [63:0] MROW = 64'hFF0F_33CC_FF00_A55A;
    localparam logic [63:0] VROW = 64'h0000_0F0F_5A5A_3C3C;
    logic        clk, rst, regWrEn, regRdEn, lineStart, memReq, memAck;
    logic        pixValid, pixIndexed, outValid;
    logic [7:0]  regIndex, regWrData, regRdData;
    logic [11:0] posX, posY, lineNum, pixX;
    logic [15:0] pixIdx, lutAddr;
    logic [23:0] pixRgb, lutData, outRgb;
    logic [26:0] memAddr;
    logic [63:0] memData;
    logic [3:0]  ackWait;
    int          errTotal, checkCount, cycles;
    hco_overlay dut (.clk(clk), .rst(rst), .regIndex(regIndex),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .posX(posX), .posY(posY),
        .lineStart(lineStart), .lineNum(lineNum), .memReq(memReq),
        .memAddr(memAddr), .memAck(memAck), .memData(memData),
        .pixValid(pixValid), .pixX(pixX), .pixIdx(pixIdx), .pixRgb(pixRgb),
        .pixIndexed(pixIndexed), .lutAddr(lutAddr), .lutData(lutData),
        .outValid(outValid), .outRgb(outRgb));
    hco_mem_model mdl (.clk(clk), .rst(rst), .ackWait(ackWait),
        .memReq(memReq), .memAddr(memAddr), .memAck(memAck),
        .memData(memData), .lutAddr(lutAddr), .lutData(lutData));
    // Clock and cycle ceiling
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errTotal++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        checkCount++;
        if (s !== e) begin
            errTotal++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    // Register port cycles, one idle cycle between strobes
    task automatic wr(input logic [7:0] i, d);
        @(negedge clk);
        regIndex = i;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, e);
        @(negedge clk);
        regIndex = i;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        chk("regRdData", regRdData, e);
    endtask
    // Start a line and wait for its fetch to finish
    task automatic fetch(input logic [11:0] n, input logic hit);
        int k;
        lineNum = n;
        lineStart = 1'b1;
        @(negedge clk);
        lineStart = 1'b0;
        @(negedge clk);
        chk("memReq", memReq, hit);
        for (k = 0; k < 40 && memReq !== 1'b0; k++) @(negedge clk);
        chk("memReqEnd", memReq, 1'b0);
    endtask
    function automatic logic [23:0] colour_lookup_table(input logic [15:0] a);
        return {a[7:0], a[15:8], a[7:0] ^ 8'h5A};
    endfunction
    // Columns 98 to 165 around the region at 100
    task automatic sweep(input logic hit, ix, pre);
        logic [11:0] c;
        logic [5:0]  b;
        logic [1:0]  mv;
        logic [23:0] e;
        logic [15:0] la;
        for (int x = 98; x < 166; x++) begin
            c = 12'(x) - 12'h064;
            b = {c[5:3], ~c[2:0]};
            mv = {MROW[b], VROW[b]};
            pixX = 12'(x);
            pixIdx = {4'hC, pixX};
            pixRgb = {pixX, 12'h5A3};
            pixIndexed = ix;
            pixValid = 1'b1;
            e = ix ? colour_lookup_table(pixIdx) : pixRgb;
            la = pixIdx;
            if (hit && x >= 100 && x < 164) begin
                if (mv == 2'b11 && ix && pre) la = ~pixIdx;
                if (mv == 2'b00) e = 24'h112233;
                if (mv == 2'b01) e = 24'hA0B0C0;
                if (mv == 2'b11) e = ix && pre ? colour_lookup_table(~pixIdx) : ~e;
            end
            @(negedge clk);
            pixValid = 1'b0;
            @(negedge clk);
            chk("lutAddr", lutAddr, la);
            @(negedge clk);
            chk("outValid", outValid, 1'b1);
            chk("outRgb", outRgb, e);
        end
    endtask
    task automatic t_reset();
        rd(8'h29, 8'h00);
        rd(8'h33, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_regs();
        logic [7:0] i;
        logic [7:0] m;
        for (i = 8'h29; i < 8'h33; i++) wr(i, 8'h83 ^ i);
        for (i = 8'h29; i < 8'h33; i++) begin
            m = i == 8'h30 ? 8'hFE : i == 8'h32 ? 8'h07 : 8'hFF;
            rd(i, (8'h83 ^ i) & m);
        end
        // Write then read back to back
        @(negedge clk);
        regIndex = 8'h29;
        regWrData = 8'h06;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        chk("height", regRdData, 8'h06);
        $display("t_regs done");
    endtask
    task automatic t_cursor();
        logic [47:0] c;
        c = 48'h112233_A0B0C0;
        for (int k = 0; k < 6; k++) wr(8'h2A + 8'(k), c[47 - 8 * k -: 8]);
        wr(8'h30, 8'h04);
        wr(8'h31, 8'h12);
        wr(8'h32, 8'h05);
        fetch(12'h015, 1'b1);
        chk("invAddr", mdl.lastAddr_ff, 27'h5120628);
        sweep(1'b1, 1'b0, 1'b0);
        sweep(1'b1, 1'b1, 1'b0);
        wr(8'h29, 8'h86);
        sweep(1'b1, 1'b1, 1'b1);
        sweep(1'b1, 1'b0, 1'b1);
        $display("t_cursor done");
    endtask
    task automatic t_miss();
        wr(8'h29, 8'h06);
        // Row past the line in use hides the cursor
        posY = 12'h017;
        fetch(12'h016, 1'b0);
        posY = 12'h010;
        fetch(12'h016, 1'b0);
        sweep(1'b0, 1'b0, 1'b0);
        ackWait = 4'h0;
        fetch(12'h011, 1'b1);
        chk("invAddr", mdl.lastAddr_ff, 27'h5120608);
        sweep(1'b1, 1'b0, 1'b0);
        wr(8'h29, 8'h00);
        fetch(12'h011, 1'b0);
        sweep(1'b0, 1'b1, 1'b0);
        $display("t_miss done");
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        {regWrEn, regRdEn, lineStart, pixValid, pixIndexed} = 5'h00;
        {regIndex, regWrData, lineNum, pixX, pixIdx, pixRgb} = 80'h0;
        posX = 12'h064;
        posY = 12'h010;
        ackWait = 4'h3;
        for (int k = 1; k < 6; k += 4) begin
            mdl.memWord[k] = MROW;
            mdl.memWord[k + 64] = VROW;
        end
        // Two rising edges in reset, release off the edge
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_regs();
        t_cursor();
        t_miss();
        stop_test();
    end
endmodule
